// File: src/dit_bank_timer.sv
`timescale 1ns/100ps
module dit_bank_timer #(
  parameter logic [2:0] BANK = 3'h0
) (
  // clocking
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  ce,
  // issued commands
  dit_cmd_if.snk     cmd,
  // thresholds in cycles
  input  wire logic [15:0] ras_c,
  input  wire logic [15:0] rcd_c,
  input  wire logic [15:0] rtp_c,
  input  wire logic [15:0] wrp_c,
  // state
  output logic       open,
  output logic       col_ok,
  output logic       pre_ok
);
  logic [15:0] ras;
  logic [15:0] rcd;
  logic [15:0] pg;
  logic [15:0] since_act;
  logic        hit;

  assign hit    = cmd.vld && cmd.bank == BANK;
  assign col_ok = open && rcd == 16'h0;
  assign pre_ok = ras == 16'h0 && pg == 16'h0;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      open <= 1'b0;
      ras  <= 16'h0;
      rcd  <= 16'h0;
      pg   <= 16'h0;
    end
    else if (ce)
    begin
      ras <= (ras != 16'h0) ? ras - 16'h1 : ras;
      rcd <= (rcd != 16'h0) ? rcd - 16'h1 : rcd;
      pg  <= (pg != 16'h0) ? pg - 16'h1 : pg;
      if (hit && cmd.kind == dit_pkg::K_ACT)
      begin
        open <= 1'b1;
        ras  <= ras_c - 16'h1; // R8
        rcd  <= rcd_c - 16'h1; // R9
      end
      if (hit && cmd.kind == dit_pkg::K_PRE)
        open <= 1'b0;
      if (hit && cmd.kind == dit_pkg::K_RD && rtp_c - 16'h1 > pg)
        pg <= rtp_c - 16'h1; // R15
      if (hit && cmd.kind == dit_pkg::K_WR && wrp_c - 16'h1 > pg)
        pg <= wrp_c - 16'h1; // R20
    end

  // checking aid: cycles since this bank was activated
  always_ff @(posedge clk)
    if (sys_rst)
      since_act <= 16'hffff;
    else if (ce)
      since_act <= (hit && cmd.kind == dit_pkg::K_ACT) ? 16'h1
        : (since_act == 16'hffff) ? since_act : since_act + 16'h1;

  property p_ras;
    @(posedge clk) disable iff (sys_rst)
    hit && cmd.kind == dit_pkg::K_PRE |-> since_act >= ras_c;
  endproperty
  a_ras: assert property (p_ras) // R8
    else $error("precharge before active-to-precharge minimum");

  property p_rcd;
    @(posedge clk) disable iff (sys_rst)
    hit && (cmd.kind == dit_pkg::K_RD || cmd.kind == dit_pkg::K_WR)
      |-> open && since_act >= rcd_c;
  endproperty
  a_rcd: assert property (p_rcd) // R9
    else $error("column command before activate-to-column delay");
endmodule

// File: src/dit_cmd_if.sv
`timescale 1ns/100ps
interface dit_cmd_if;
  logic              vld;
  dit_pkg::dit_kind_t kind;
  logic [2:0]        bank;
  modport src (output vld, kind, bank);
  modport snk (input vld, kind, bank);
endinterface

// File: src/dit_pkg.sv
package dit_pkg;
  // clock period in ns, used to turn nanosecond minimums into cycles
  localparam int unsigned CLK_PERIOD_NS = 10;

  // register byte offsets
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_LAT  = 5'h04;
  localparam logic [4:0] A_TA   = 5'h08;
  localparam logic [4:0] A_TB   = 5'h0c;
  localparam logic [4:0] A_TC   = 5'h10;
  localparam logic [4:0] A_STAT = 5'h14;

  // control field positions
  localparam int F_TYPE  = 0;
  localparam int F_PHY   = 2;
  localparam int F_ILV   = 3;
  localparam int F_SLOW  = 4;
  localparam int F_SRT   = 5;
  localparam int F_BL8   = 6;
  localparam logic [1:0] TYPE_DDR2 = 2'h0;

  // reset values: bl8, rl 5, al 0, wl 4, timings in ns
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [31:0] LAT_RST  = 32'h0000_0405;
  // ras 40, rcd 15, rtp 8, wr 15
  localparam logic [31:0] TA_RST   = 32'h0f08_0f28;
  // rrd 10, faw 50, wtr 8, mrd 20
  localparam logic [31:0] TB_RST   = 32'h1408_320a;
  // refi 7800, rfc 128
  localparam logic [31:0] TC_RST   = 32'h1e78_0080;

  localparam int unsigned T_INIT_NS = 200000;
  localparam int unsigned INIT_CYC  =
    (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refresh is flagged this many cycles early so open rows can close
  localparam logic [15:0] REF_LEAD = 16'h0040;

  typedef enum logic [2:0] {
    K_NOP = 3'h0, K_ACT = 3'h1, K_RD  = 3'h2, K_WR = 3'h3,
    K_PRE = 3'h4, K_REF = 3'h5, K_MRS = 3'h6
  } dit_kind_t;

  function automatic logic [15:0] ns2cyc(input logic [15:0] ns);
    logic [16:0] c;
    c = (17'(ns) + 17'(CLK_PERIOD_NS - 1)) / 17'(CLK_PERIOD_NS);
    return (c == 17'h0) ? 16'h0001 : c[15:0];
  endfunction
endpackage

// File: src/dit_refresh.sv
`timescale 1ns/100ps
module dit_refresh (
  // clocking
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  ce,
  // issued commands
  dit_cmd_if.snk     cmd,
  // control
  input  wire logic  run,
  input  wire logic [15:0] refi_c,
  input  wire logic [15:0] rfc_c,
  // state
  output logic       due,
  output logic       busy
);
  logic [15:0] cnt;
  logic [15:0] rfc;
  logic [15:0] since_ref;
  logic        ref_hit;

  assign ref_hit = cmd.vld && cmd.kind == dit_pkg::K_REF;
  assign busy    = rfc != 16'h0;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      cnt <= 16'h0;
      rfc <= 16'h0;
      due <= 1'b0;
    end
    else if (ce)
    begin
      rfc <= busy ? rfc - 16'h1 : rfc;
      if (!run || ref_hit)
      begin
        cnt <= refi_c - 16'h1; // R10
        due <= 1'b0;
      end
      else
      begin
        cnt <= (cnt != 16'h0) ? cnt - 16'h1 : cnt;
        if (cnt <= dit_pkg::REF_LEAD)
          due <= 1'b1; // R10
      end
      if (ref_hit)
        rfc <= rfc_c - 16'h1; // R11
    end

  always_ff @(posedge clk)
    if (sys_rst)
      since_ref <= 16'hffff;
    else if (ce)
      since_ref <= ref_hit ? 16'h1
        : (since_ref == 16'hffff) ? since_ref : since_ref + 16'h1;

  property p_rfc;
    @(posedge clk) disable iff (sys_rst)
    cmd.vld && cmd.kind != dit_pkg::K_NOP |-> since_ref >= rfc_c;
  endproperty
  a_rfc: assert property (p_rfc) // R11
    else $error("command issued inside refresh cycle time");

  property p_refi;
    @(posedge clk) disable iff (sys_rst)
    run && ref_hit |-> since_ref == 16'hffff || since_ref <= refi_c;
  endproperty
  a_refi: assert property (p_refi) // R10
    else $error("refresh interval exceeded");
endmodule

// File: src/dit_top.sv
// What this block does
// [R1] With the built-in controller, mode register gets sequential order.
// [R2] Interleaved order only selectable in PHY-only custom-controller mode.
// [R3] Configured burst length goes to mode register and sizes each burst.
// [R4] First read data expected exactly read latency cycles after read.
// [R5] Additive latency is programmed and added to read/write latencies.
// [R6] DDR2 init programs DLL slow or fast power-down exit.
// [R7] DDR2 self-refresh temperature selects normal or doubled refresh rate.
// [R8] No precharge before active-to-precharge minimum since activate.
// [R9] No read or write before activate-to-column delay.
// [R10] Refresh issued at average interval, never exceeded.
// [R11] After refresh wait refresh cycle time before bank commands.
// [R12] Write-to-read delay held after write data ends.
// [R13] At most four activates in any four-activate window.
// [R14] Activates spaced by activate-to-activate delay.
// [R15] Read-to-precharge time kept before precharging same bank.
// [R16] Mode-register commands and the next command spaced by tMRD.
// [R17] Wait initialization time after power-up before normal traffic.
// [R18] Local data word is four times the memory data width.
// [R19] Nanosecond minimums round up to whole cycles used as thresholds.
// [R20] Write recovery time kept before precharging written bank.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module dit_top #(
  parameter int unsigned INIT_CYC = dit_pkg::INIT_CYC
) (
  // clocking
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // register bus
  input  wire logic [4:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // core command port
  input  wire logic         cmd_valid,
  input  wire logic [2:0]   cmd_kind,
  input  wire logic [2:0]   cmd_bank,
  input  wire logic [13:0]  cmd_addr,
  input  wire logic [63:0]  local_wdata,
  output logic              cmd_ack,
  // memory side
  output logic [2:0]        mem_cmd,
  output logic [2:0]        mem_bank,
  output logic [13:0]       mem_addr,
  output logic [15:0]       mem_wdata [4],
  output logic              rd_expect,
  output logic              init_done
);
  typedef enum logic [2:0] {
    S_WAIT = 3'b001, S_MR = 3'b010, S_RUN = 3'b100
  } dit_state_t;

  dit_state_t         state;
  dit_pkg::dit_kind_t iss_kind;
  logic [2:0]         iss_bank;
  logic [13:0]        iss_addr;
  logic [31:0]        ctrl, lat, ta, tb, tc;
  logic [31:0]        init_cnt;
  logic [1:0]         mr_idx;
  logic [15:0]        mrd, col, wtr, rrd;
  logic [15:0]        faw_t [4];
  logic [1:0]         faw_p;
  logic [31:0]        rd_sr;
  logic [7:0]         open, col_ok, pre_ok;
  logic               ref_due, ref_busy, gate, ilv, ddr2;
  logic [4:0]         half, rl_tot, wl_tot;
  logic [15:0]        ras_c, rcd_c, rtp_c, wr_c, rrd_c, faw_c, wtr_c;
  logic [15:0]        mrd_c, rfc_c, refi_c, wrp_c, wtr_x;
  logic [31:0]        rd_mux;
  logic               req;
  logic [15:0]        since_col, since_wr, since_act, since_mrs;

  dit_cmd_if cmd_bus ();

  ////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign ddr2   = ctrl[dit_pkg::F_TYPE +: 2] == dit_pkg::TYPE_DDR2;
  assign ilv    = ctrl[dit_pkg::F_PHY] && ctrl[dit_pkg::F_ILV]; // R1 R2
  assign half   = ctrl[dit_pkg::F_BL8] ? 5'h4 : 5'h2; // R3
  assign rl_tot = 5'(lat[3:0]) + 5'(lat[7:4]); // R4 R5
  assign wl_tot = 5'(lat[11:8]) + 5'(lat[7:4]); // R5
  assign ras_c  = dit_pkg::ns2cyc({8'h0, ta[7:0]}); // R19
  assign rcd_c  = dit_pkg::ns2cyc({8'h0, ta[15:8]}); // R19
  assign rtp_c  = dit_pkg::ns2cyc({8'h0, ta[23:16]}); // R19
  assign wr_c   = dit_pkg::ns2cyc({8'h0, ta[31:24]}); // R19
  assign rrd_c  = dit_pkg::ns2cyc({8'h0, tb[7:0]}); // R19
  assign faw_c  = dit_pkg::ns2cyc({8'h0, tb[15:8]}); // R19
  assign wtr_c  = dit_pkg::ns2cyc({8'h0, tb[23:16]}); // R19
  assign mrd_c  = dit_pkg::ns2cyc({8'h0, tb[31:24]}); // R19
  assign rfc_c  = dit_pkg::ns2cyc(tc[15:0]); // R19
  // doubled rate halves the interval
  assign refi_c = (ddr2 && ctrl[dit_pkg::F_SRT])
    ? dit_pkg::ns2cyc({1'b0, tc[31:17]}) // R7
    : dit_pkg::ns2cyc(tc[31:16]);
  // write data ends wl + half cycles after the command
  assign wrp_c  = 16'(wl_tot) + 16'(half) + wr_c; // R20
  assign wtr_x  = 16'(wl_tot) + 16'(half) + wtr_c; // R12

  ////////////////////////////////////////////////////////////////////////
  // register bus slave, one wait cycle per access

  assign req = avs_read || avs_write;

  always_comb
  begin
    unique case (avs_address)
      dit_pkg::A_CTRL: rd_mux = ctrl;
      dit_pkg::A_LAT:  rd_mux = lat;
      dit_pkg::A_TA:   rd_mux = ta;
      dit_pkg::A_TB:   rd_mux = tb;
      dit_pkg::A_TC:   rd_mux = tc;
      dit_pkg::A_STAT: rd_mux = {21'h0, open, ref_busy, ref_due, init_done};
      default:         rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else if (ce)
    begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_mux;
    end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      ctrl <= dit_pkg::CTRL_RST;
      lat  <= dit_pkg::LAT_RST;
      ta   <= dit_pkg::TA_RST;
      tb   <= dit_pkg::TB_RST;
      tc   <= dit_pkg::TC_RST;
    end
    else if (ce && avs_write && !avs_waitrequest)
      unique case (avs_address)
        dit_pkg::A_CTRL: ctrl <= {24'h0, avs_writedata[7:0]};
        dit_pkg::A_LAT:  lat  <= {20'h0, avs_writedata[11:0]};
        dit_pkg::A_TA:   ta   <= avs_writedata;
        dit_pkg::A_TB:   tb   <= avs_writedata;
        dit_pkg::A_TC:   tc   <= avs_writedata;
        default:         ;
      endcase

  ////////////////////////////////////////////////////////////////////////
  // power-up wait and mode-register load

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      state     <= S_WAIT;
      init_cnt  <= 32'h0;
      mr_idx    <= 2'h0;
      init_done <= 1'b0;
    end
    else if (ce)
      unique case (state)
        S_WAIT:
          if (init_cnt >= INIT_CYC - 1)
            state <= S_MR; // R17
          else
            init_cnt <= init_cnt + 32'h1;
        S_MR:
          if (iss_kind == dit_pkg::K_MRS)
          begin
            mr_idx <= mr_idx + 2'h1;
            if (mr_idx == 2'h2)
            begin
              state     <= S_RUN;
              init_done <= 1'b1;
            end
          end
        S_RUN: ;
      endcase

  ////////////////////////////////////////////////////////////////////////
  // command selection; refresh beats the core

  assign gate = ce && mrd == 16'h0 && !cmd_ack; // R16

  always_comb
  begin
    iss_kind = dit_pkg::K_NOP;
    iss_bank = cmd_bank;
    iss_addr = cmd_addr;
    if (state == S_MR && gate)
    begin
      iss_kind = dit_pkg::K_MRS;
      iss_bank = {1'b0, mr_idx};
      unique case (mr_idx)
        2'h0: iss_addr = {1'b0, ddr2 && ctrl[dit_pkg::F_SLOW], // R6
          5'h0, lat[2:0], ilv, // R1 R2 R4
          2'h1, ctrl[dit_pkg::F_BL8]}; // R3
        2'h1: iss_addr = {8'h0, lat[6:4], 3'h0}; // R5
        default: iss_addr = {6'h0, ddr2 && ctrl[dit_pkg::F_SRT], // R7
          7'h0};
      endcase
    end
    else if (state == S_RUN && gate && !ref_busy) // R11
    begin
      if (ref_due)
      begin
        if (open == 8'h0)
          iss_kind = dit_pkg::K_REF; // R10
      end
      if (cmd_valid && iss_kind == dit_pkg::K_NOP)
        unique case (cmd_kind)
          dit_pkg::K_ACT:
            if (!ref_due && !open[cmd_bank] && rrd == 16'h0 // R14
              && faw_t[faw_p] == 16'h0) // R13
              iss_kind = dit_pkg::K_ACT;
          dit_pkg::K_RD:
            if (col_ok[cmd_bank] && col == 16'h0 && wtr == 16'h0) // R12
              iss_kind = dit_pkg::K_RD;
          dit_pkg::K_WR:
            if (col_ok[cmd_bank] && col == 16'h0) // R3
              iss_kind = dit_pkg::K_WR;
          dit_pkg::K_PRE:
            if (pre_ok[cmd_bank])
              iss_kind = dit_pkg::K_PRE;
          default: ;
        endcase
    end
  end

  assign cmd_bus.vld  = iss_kind != dit_pkg::K_NOP;
  assign cmd_bus.kind = iss_kind;
  assign cmd_bus.bank = iss_bank;

  ////////////////////////////////////////////////////////////////////////
  // shared spacing counters

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      mrd   <= 16'h0;
      col   <= 16'h0;
      wtr   <= 16'h0;
      rrd   <= 16'h0;
      faw_p <= 2'h0;
      for (int i = 0; i < 4; i++)
        faw_t[i] <= 16'h0;
    end
    else if (ce)
    begin
      mrd <= (mrd != 16'h0) ? mrd - 16'h1 : mrd;
      col <= (col != 16'h0) ? col - 16'h1 : col;
      wtr <= (wtr != 16'h0) ? wtr - 16'h1 : wtr;
      rrd <= (rrd != 16'h0) ? rrd - 16'h1 : rrd;
      for (int i = 0; i < 4; i++)
        faw_t[i] <= (faw_t[i] != 16'h0) ? faw_t[i] - 16'h1 : faw_t[i];
      if (iss_kind == dit_pkg::K_MRS)
        mrd <= mrd_c - 16'h1; // R16
      if (iss_kind == dit_pkg::K_RD || iss_kind == dit_pkg::K_WR)
        col <= 16'(half) - 16'h1; // R3
      if (iss_kind == dit_pkg::K_WR)
        wtr <= wtr_x - 16'h1; // R12
      if (iss_kind == dit_pkg::K_ACT)
      begin
        rrd          <= rrd_c - 16'h1; // R14
        faw_t[faw_p] <= faw_c - 16'h1; // R13
        faw_p        <= faw_p + 2'h1;
      end
    end

  ////////////////////////////////////////////////////////////////////////
  // per-bank timers and refresh

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bank
      dit_bank_timer #(.BANK(3'(b))) u_bank (
        .clk    (clk),
        .sys_rst(sys_rst),
        .ce     (ce),
        .cmd    (cmd_bus),
        .ras_c  (ras_c),
        .rcd_c  (rcd_c),
        .rtp_c  (rtp_c),
        .wrp_c  (wrp_c),
        .open   (open[b]),
        .col_ok (col_ok[b]),
        .pre_ok (pre_ok[b])
      );
    end
  endgenerate

  dit_refresh u_ref (
    .clk    (clk),
    .sys_rst(sys_rst),
    .ce     (ce),
    .cmd    (cmd_bus),
    .run    (state == S_RUN),
    .refi_c (refi_c),
    .rfc_c  (rfc_c),
    .due    (ref_due),
    .busy   (ref_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // memory-side outputs and read data timing

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      mem_cmd   <= dit_pkg::K_NOP;
      mem_bank  <= 3'h0;
      mem_addr  <= 14'h0;
      cmd_ack   <= 1'b0;
      rd_sr     <= 32'h0;
      rd_expect <= 1'b0;
      for (int i = 0; i < 4; i++)
        mem_wdata[i] <= 16'h0;
    end
    else if (ce)
    begin
      mem_cmd  <= iss_kind;
      mem_bank <= iss_bank;
      mem_addr <= iss_addr;
      cmd_ack  <= iss_kind inside {dit_pkg::K_ACT, dit_pkg::K_RD,
                                   dit_pkg::K_WR, dit_pkg::K_PRE};
      rd_sr    <= {rd_sr[30:0], iss_kind == dit_pkg::K_RD};
      // rd_sr[k] is mem_cmd delayed k; one more flop lands on rl_tot
      rd_expect <= rl_tot != 5'h0 && rd_sr[rl_tot - 5'h1]; // R4 R5
      // half rate: four memory beats per local word
      if (iss_kind == dit_pkg::K_WR)
        for (int i = 0; i < 4; i++)
          mem_wdata[i] <= local_wdata[16*i +: 16]; // R18
    end

  ////////////////////////////////////////////////////////////////////////
  // checking aids

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      since_col <= 16'hffff;
      since_wr  <= 16'hffff;
      since_act <= 16'hffff;
      since_mrs <= 16'hffff;
    end
    else if (ce)
    begin
      since_col <= (iss_kind inside {dit_pkg::K_RD, dit_pkg::K_WR}) ? 16'h1
        : (since_col == 16'hffff) ? since_col : since_col + 16'h1;
      since_wr <= (iss_kind == dit_pkg::K_WR) ? 16'h1
        : (since_wr == 16'hffff) ? since_wr : since_wr + 16'h1;
      since_act <= (iss_kind == dit_pkg::K_ACT) ? 16'h1
        : (since_act == 16'hffff) ? since_act : since_act + 16'h1;
      since_mrs <= (iss_kind == dit_pkg::K_MRS) ? 16'h1
        : (since_mrs == 16'hffff) ? since_mrs : since_mrs + 16'h1;
    end

  property p_init;
    @(posedge clk) disable iff (sys_rst)
    iss_kind != dit_pkg::K_NOP |-> init_cnt >= INIT_CYC - 1;
  endproperty
  a_init: assert property (p_init) // R17
    else $error("command before initialization time");

  property p_mrd;
    @(posedge clk) disable iff (sys_rst)
    iss_kind != dit_pkg::K_NOP |-> since_mrs >= mrd_c;
  endproperty
  a_mrd: assert property (p_mrd) // R16
    else $error("command too soon after mode-register load");

  property p_seq;
    @(posedge clk) disable iff (sys_rst)
    mem_cmd == dit_pkg::K_MRS && mem_bank == 3'h0 && mem_addr[3]
      |-> $past(ctrl[dit_pkg::F_PHY]);
  endproperty
  a_seq: assert property (p_seq) // R1 R2
    else $error("interleaved burst order with built-in controller");

  property p_bl;
    @(posedge clk) disable iff (sys_rst)
    iss_kind inside {dit_pkg::K_RD, dit_pkg::K_WR}
      |-> since_col >= 16'(half);
  endproperty
  a_bl: assert property (p_bl) // R3
    else $error("column commands closer than one burst");

  property p_wtr;
    @(posedge clk) disable iff (sys_rst)
    iss_kind == dit_pkg::K_RD |-> since_wr >= wtr_x;
  endproperty
  a_wtr: assert property (p_wtr) // R12
    else $error("read too soon after write data");

  property p_rrd;
    @(posedge clk) disable iff (sys_rst)
    iss_kind == dit_pkg::K_ACT |-> since_act >= rrd_c;
  endproperty
  a_rrd: assert property (p_rrd) // R14
    else $error("activates closer than activate-to-activate delay");

  property p_rd_lat;
    @(posedge clk) disable iff (sys_rst)
    ce && iss_kind == dit_pkg::K_RD && rl_tot == 5'h5
      ##1 ce [*5] |=> rd_expect;
  endproperty
  a_rd_lat: assert property (p_rd_lat) // R4 R5
    else $error("read data expectation off its latency");

  c_init: cover property (@(posedge clk) $rose(init_done));
  c_ref: cover property (@(posedge clk) iss_kind == dit_pkg::K_REF);
  c_wr_rd: cover property (@(posedge clk)
    iss_kind == dit_pkg::K_RD && since_wr < 16'h0020);
endmodule

// File: tb/dit_mem_model.sv
`timescale 1ns/100ps
module dit_mem_model (
  // command bus
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  mem_cmd,
  input  wire logic [2:0]  mem_bank,
  // faults seen
  output logic [15:0]      perr
);
  logic [7:0] open_b;
  logic       bad;
  // double activate, column access to a closed row, refresh with rows open
  assign bad = (mem_cmd == 3'h1 && open_b[mem_bank]) ||
    ((mem_cmd == 3'h2 || mem_cmd == 3'h3) && !open_b[mem_bank]) ||
    (mem_cmd == 3'h5 && open_b != 8'h00);
  always @(posedge clk)
  begin
    if (sys_rst)
      open_b <= 8'h00;
    else if (mem_cmd == 3'h1)
      open_b[mem_bank] <= 1'b1;
    else if (mem_cmd == 3'h4)
      open_b[mem_bank] <= 1'b0;
    if (sys_rst)
      perr <= 16'h0000;
    else if (bad)
      perr <= perr + 16'h0001;
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk, sys_rst, ce, avs_read, avs_write, cmd_valid;
  logic        avs_waitrequest, cmd_ack, rd_expect, init_done;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, lat, seed;
  logic [2:0]  cmd_kind, cmd_bank, mem_cmd, mem_bank;
  logic [13:0] cmd_addr, mem_addr;
  logic [63:0] local_wdata;
  logic [15:0] mem_wdata [4];
  logic [15:0] perr;
  logic [63:0] rd_q[$], wd_q[$];
  int          lat_q[$];
  int          fails, checked, cyc, al, rl, na, nmrs, nref, wd_due, seen;
  int          act_t[8], rd_t[8], wr_t[8], act4[4], lwr, lrd, lmrs, lref;

  dit_top #(.INIT_CYC(50)) uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
    .cmd_addr(cmd_addr), .local_wdata(local_wdata), .cmd_ack(cmd_ack),
    .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .rd_expect(rd_expect), .init_done(init_done));
  dit_mem_model mem (.clk(clk), .sys_rst(sys_rst), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .perr(perr));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [63:0] e, g);
    checked++;
    if (e !== g)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic ge(input string n, input int lo, input int g);
    chk(n, 64'h1, 64'(g >= lo));
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(64'(e));
    bus(1'b0, a, 32'h0);
  endtask
  task automatic core(input logic [2:0] k, b);
    logic [63:0] w;
    w = {$random(seed), $random(seed)};
    @(posedge clk);
    cmd_kind <= k;
    cmd_bank <= b;
    cmd_addr <= 14'($random(seed));
    local_wdata <= w;
    cmd_valid <= 1'b1;
    if (k == 3'h3)
      wd_q.push_back(w);
    if (k == 3'h2)
      lat_q.push_back(rl + al);
    do @(posedge clk); while (cmd_ack !== 1'b1);
    cmd_valid <= 1'b0;
  endtask

  // result watcher: gaps in cycles between commands seen on the memory side
  always @(posedge clk)
  begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0)
      chk("readdata", rd_q.pop_front(), 64'(avs_readdata));
    if (wd_due == cyc)
      chk("wdata", wd_q.pop_front(), {mem_wdata[3], mem_wdata[2],
        mem_wdata[1], mem_wdata[0]});
    if (rd_expect === 1'b1)
      chk("rd_lat", 64'(lat_q.pop_front()), 64'(cyc - lrd));
    if (mem_cmd == 3'h1)
    begin
      ge("trrd", 3, cyc - act4[(na + 3) % 4]);
      ge("tfaw", 15, cyc - act4[na % 4]);
      ge("trfc", 13, cyc - lref);
      ge("tmrd", 2, cyc - lmrs);
      act4[na % 4] = cyc;
      na++;
      act_t[mem_bank] = cyc;
    end
    if (mem_cmd == 3'h2 || mem_cmd == 3'h3)
      ge("trcd", 2, cyc - act_t[mem_bank]);
    if (mem_cmd == 3'h2)
    begin
      ge("twtr", 9 + al, cyc - lwr);
      lrd = cyc;
      rd_t[mem_bank] = cyc;
    end
    if (mem_cmd == 3'h3)
    begin
      lwr = cyc;
      wr_t[mem_bank] = cyc;
      wd_due = cyc + 1;
    end
    if (mem_cmd == 3'h4)
    begin
      ge("tras", 4, cyc - act_t[mem_bank]);
      ge("trtp", 8, cyc - rd_t[mem_bank]);
      ge("twr", 10 + al, cyc - wr_t[mem_bank]);
    end
    if (mem_cmd == 3'h5)
    begin
      if (nref > 0)
        // doubled refresh rate halves the 780-cycle interval
        ge("trefi", cyc - lref, 390);
      lref = cyc;
      nref++;
    end
    if (mem_cmd == 3'h6)
    begin
      ge("tmrd", 2, cyc - lmrs);
      lmrs = cyc;
      nmrs++;
      if (mem_bank == 3'h0)
        chk("mr0", {1'b1, 3'(rl), 4'h3},
          {mem_addr[12], mem_addr[6:0]});
      if (mem_bank == 3'h1)
        chk("mr1", 64'(al), 64'(mem_addr[5:3]));
      if (mem_bank == 3'h2)
        chk("mr2", 64'h1, 64'(mem_addr[7]));
    end
    // after the mrs count: third mrs and init_done share one edge
    if (init_done === 1'b1 && seen == 0)
    begin
      seen = 1;
      ge("init_time", 70, cyc);
      chk("mrs_count", 64'h3, 64'(nmrs));
    end
  end

  // watchdog: whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results;
  end

  initial
  begin
    clk = 0;
    sys_rst = 1;
    ce = 1;
    {avs_read, avs_write, cmd_valid} = 3'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    {cmd_kind, cmd_bank, cmd_addr, local_wdata} = '0;
    {fails, checked, cyc, na, nmrs, nref, wd_due, seen} = '0;
    lwr = -1000;
    lrd = -1000;
    lmrs = -1000;
    lref = -1000;
    act4 = '{default: -1000};
    act_t = '{default: -1000};
    rd_t = '{default: -1000};
    wr_t = '{default: -1000};
    seed = 32'h9b92;
    // split varies but the sum stays five, so the latency property fires
    rl = 3 + ($unsigned($random(seed)) % 3);
    al = 5 - rl;
    lat = $random(seed);
    lat[11:0] = {4'h4, 4'(al), 4'(rl)};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // interleave asked for without phy-only: must stay sequential
    bus(1'b1, 5'h00, 32'h0000_0f78);
    bus(1'b1, 5'h04, lat);
    bus(1'b1, 5'h08, 32'h0f4b_0f28);
    bus(1'b1, 5'h0c, 32'h1408_961e);
    rd(5'h00, 32'h0000_0078);
    rd(5'h04, {20'h0, lat[11:0]});
    rd(5'h08, 32'h0f4b_0f28);
    rd(5'h0c, 32'h1408_961e);
    rd(5'h10, 32'h1e78_0080);
    rd(5'h18, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 500 && init_done !== 1'b1; i++)
      @(posedge clk);
    chk("init_done", 64'h1, 64'(init_done));
    $display("test init done");
    core(3'h1, 3'h1);
    core(3'h2, 3'h1);
    core(3'h3, 3'h1);
    core(3'h2, 3'h1);
    core(3'h4, 3'h1);
    for (int b = 0; b < 5; b++)
      core(3'h1, 3'(b));
    for (int b = 0; b < 5; b++)
      core(3'h4, 3'(b));
    $display("test traffic done");
    for (int i = 0; i < 2000 && nref < 2; i++)
      @(posedge clk);
    core(3'h1, 3'h2);
    core(3'h4, 3'h2);
    chk("refreshes", 64'h1, 64'(nref >= 2));
    $display("test refresh done");
    repeat (20) @(posedge clk);
    chk("lat_left", 64'h0, 64'(lat_q.size()));
    chk("protocol", 64'h0, 64'(perr));
    results;
  end
endmodule
